// [design/irq_unit.sv]
`include "irq_defs.svh"

module irq_unit (
	// clock and reset
	input  wire logic                clk,
	input  wire logic                rst_n,
	// avalon-mm slave
	input  wire logic [7:0]          address,
	input  wire logic                read,
	input  wire logic                write,
	input  wire logic [31:0]         writedata,
	input  wire logic [3:0]          byteenable,
	output logic      [31:0]         readdata,
	output logic                     waitrequest,
	// condition pulses
	input  wire logic [7:0]          scsi_evt0,
	input  wire logic [7:0]          scsi_evt1,
	input  wire logic [6:0]          dma_evt,
	input  wire logic                otf_evt,
	// engine side
	input  wire logic                dma_fifo_empty,
	input  irq_pkg::eng_status_t     eng,
	output logic                     halted,
	output logic                     flush_req,
	output logic                     skip_exec,
	output logic                     load_jump_addr,
	// interrupt request
	output logic                     irq_n
);
	// =====================================
	// state
	logic [7:0]  flags0;
	logic [7:0]  flags1;
	logic [6:0]  dflags;
	logic [7:0]  stk0;
	logic [7:0]  stk1;
	logic [6:0]  stkd;
	logic        otf;
	logic        irq_on;
	logic [1:0]  gap;
	logic        ack;
	logic [31:0] rdata;
	logic [7:0]  mask0;
	logic [7:0]  mask1;
	logic [6:0]  maskd;
	logic [1:0]  ctl1;

	logic [7:0]  pc0;
	logic [7:0]  pc1;
	logic [7:0]  hc0;
	logic [7:0]  hc1;

	// =====================================
	// bus decode
	wire req     = read | write;
	wire take    = req & ack;
	wire be0     = byteenable[0];
	wire sel_sum = (address == `OFS_SUMMARY);
	wire sel_f0  = (address == `OFS_SFLAGS0);
	wire sel_f1  = (address == `OFS_SFLAGS1);
	wire sel_fd  = (address == `OFS_DFLAGS);
	wire sel_m0  = (address == `OFS_SMASK0);
	wire sel_m1  = (address == `OFS_SMASK1);
	wire sel_md  = (address == `OFS_DMASK);
	wire sel_c1  = (address == `OFS_SCTL1);
	wire wr_ok   = take & write & be0;

	wire clr0    = take & read & sel_f0;
	wire clr1    = take & read & sel_f1;
	wire clrd    = take & read & sel_fd;
	wire clr_any = clr0 | clr1 | clrd;
	wire otf_w1c = wr_ok & sel_sum & writedata[`SUM_OTF];
	wire restart = wr_ok & sel_sum & writedata[`SUM_RESTART];

	assign waitrequest = req & ~ack;

	// =====================================
	// classification
	irq_sort u_sort (
		.target          (ctl1[`CTL_TARGET]),
		.no_halt_on_attn (ctl1[`CTL_NO_HALT]),
		.en0             (mask0),
		.en1             (mask1),
		.pc0             (pc0),
		.pc1             (pc1),
		.hc0             (hc0),
		.hc1             (hc1)
	);

	// masked non-fatal flags do not count as pending
	wire scsi_pending = |(flags0 & pc0) | |(flags1 & pc1);
	wire dma_pending  = |dflags;
	wire any_pend     = scsi_pending | dma_pending;
	wire gap_idle     = (gap == 2'h0);

	// =====================================
	// posting and stacking
	wire post_ok_s = ~any_pend & gap_idle & dma_fifo_empty;
	wire post_ok_d = ~any_pend & gap_idle;
	wire [7:0] in0 = scsi_evt0 | stk0;
	wire [7:0] in1 = scsi_evt1 | stk1;
	wire [6:0] ind = dma_evt | stkd;
	wire [7:0] post0 = post_ok_s ? in0 : 8'h00;
	wire [7:0] post1 = post_ok_s ? in1 : 8'h00;
	wire [6:0] postd = post_ok_d ? ind : 7'h00;

	// set wins over a same-cycle clearing read
	wire [7:0] next_flags0 = (flags0 & ~{8{clr0}}) | post0;
	wire [7:0] next_flags1 = (flags1 & ~{8{clr1}}) | post1;
	wire [6:0] next_dflags = (dflags & ~{7{clrd}}) | postd;
	wire [7:0] next_stk0   = post_ok_s ? 8'h00 : in0;
	wire [7:0] next_stk1   = post_ok_s ? 8'h00 : in1;
	wire [6:0] next_stkd   = post_ok_d ? 7'h00 : ind;
	wire       next_otf    = otf_evt | (otf & ~otf_w1c);

	wire [1:0] next_gap = clr_any ? `GAP_CLKS
		: (gap_idle ? 2'h0 : gap - 2'h1);

	// =====================================
	// request output
	wire en_hit = |(flags0 & mask0) | |(flags1 & mask1)
		| |(dflags & maskd) | otf;
	wire still  = (|flags0) | (|flags1) | (|dflags) | otf;
	wire next_irq = (clr_any | ~gap_idle) ? 1'b0
		: (en_hit | (irq_on & still));

	assign irq_n = ~irq_on;

	// =====================================
	// halt trigger: on-the-fly never takes part
	wire s_halt = |(post0 & hc0) | |(post1 & hc1);
	wire trig   = s_halt | (|postd);

	halt_ctrl u_halt (
		.clk            (clk),
		.rst_n          (rst_n),
		.trig           (trig),
		.scsi_cause     (s_halt),
		.restart        (restart),
		.fifo_empty     (dma_fifo_empty),
		.eng            (eng),
		.halted         (halted),
		.flush_req      (flush_req),
		.skip_exec      (skip_exec),
		.load_jump_addr (load_jump_addr)
	);

	// =====================================
	// read mux
	wire [31:0] sum_word = {27'h0, 1'b0, halted, otf, scsi_pending, dma_pending};
	wire [31:0] rd_mux =
		sel_sum ? sum_word :
		sel_f0  ? {24'h0, flags0} :
		sel_f1  ? {24'h0, flags1} :
		sel_fd  ? {24'h0, dma_fifo_empty, dflags} :
		sel_m0  ? {24'h0, mask0} :
		sel_m1  ? {24'h0, mask1} :
		sel_md  ? {25'h0, maskd} :
		sel_c1  ? {30'h0, ctl1} : 32'h0;

	// =====================================
	// registers
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ack   <= 1'b0;
			rdata <= 32'h0;
		end else begin
			ack <= req & ~ack;
			if (read & ~ack) rdata <= rd_mux;
		end
	end

	assign readdata = rdata;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			mask0 <= `MASK_RST;
			mask1 <= `MASK_RST;
			maskd <= `DMASK_RST;
			ctl1  <= 2'h0;
		end else if (wr_ok) begin
			if (sel_m0) mask0 <= writedata[7:0];
			if (sel_m1) mask1 <= writedata[7:0];
			if (sel_md) maskd <= writedata[6:0];
			if (sel_c1) ctl1 <= writedata[1:0];
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			flags0 <= 8'h00;
			flags1 <= 8'h00;
			dflags <= 7'h00;
			stk0   <= 8'h00;
			stk1   <= 8'h00;
			stkd   <= 7'h00;
			otf    <= 1'b0;
			irq_on <= 1'b0;
			gap    <= 2'h0;
		end else begin
			flags0 <= next_flags0;
			flags1 <= next_flags1;
			dflags <= next_dflags;
			stk0   <= next_stk0;
			stk1   <= next_stk1;
			stkd   <= next_stkd;
			otf    <= next_otf;
			irq_on <= next_irq;
			gap    <= next_gap;
		end
	end

	// =====================================
	// assertions
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	property p_dma_fatal;
		(|postd) && !skip_exec |=> skip_exec;
	endproperty
	a_dma_fatal: assert property (p_dma_fatal)
		else $error("dma condition did not start a halt");

	property p_halt_trig;
		s_halt && !skip_exec |=> skip_exec;
	endproperty
	a_halt_trig: assert property (p_halt_trig)
		else $error("halting scsi condition did not start a halt");

	property p_otf_runs;
		otf_evt && !skip_exec && !trig |=> !skip_exec ##0 otf;
	endproperty
	a_otf_runs: assert property (p_otf_runs)
		else $error("on-the-fly interrupt stopped the engine");

	property p_masked_nf;
		(post0 != 8'h00) && ((post0 & pc0) == 8'h00) && (post1 == 8'h00)
			&& (postd == 7'h00) && !irq_on && !en_hit && !otf_evt
			|=> !irq_on && !scsi_pending;
	endproperty
	a_masked_nf: assert property (p_masked_nf)
		else $error("masked non-fatal condition raised a request");

	property p_mask_late;
		irq_on && !clr_any && gap_idle && still |=> irq_on;
	endproperty
	a_mask_late: assert property (p_mask_late)
		else $error("request dropped without a clearing read");

	property p_stack;
		any_pend && (scsi_evt0 != 8'h00)
			|=> ((stk0 & $past(scsi_evt0)) == $past(scsi_evt0));
	endproperty
	a_stack: assert property (p_stack)
		else $error("condition not stacked while pending");

	property p_gap;
		clr_any |=> !irq_on [*3];
	endproperty
	a_gap: assert property (p_gap)
		else $error("request not held low three clocks");

	property p_same_window;
		!any_pend && gap_idle && dma_fifo_empty && (scsi_evt0 != 8'h00)
			|=> ((flags0 & $past(scsi_evt0)) == $past(scsi_evt0));
	endproperty
	a_same_window: assert property (p_same_window)
		else $error("simultaneous condition not posted");

	property p_lockout;
		!dma_fifo_empty |=> ((flags0 & ~$past(flags0)) == 8'h00);
	endproperty
	a_lockout: assert property (p_lockout)
		else $error("scsi condition posted with dma fifo holding data");

	property p_otf_hold;
		otf && !otf_w1c |=> otf;
	endproperty
	a_otf_hold: assert property (p_otf_hold)
		else $error("on-the-fly flag cleared without a write of one");

	property p_level;
		en_hit && gap_idle && !clr_any |=> irq_on;
	endproperty
	a_level: assert property (p_level)
		else $error("enabled pending condition without request");

	property p_restack;
		clr_any && (stk0 != 8'h00) ##1 1'b1;
	endproperty
	c_restack: cover property (p_restack);

	property p_flush;
		flush_req ##1 halted;
	endproperty
	c_flush: cover property (p_flush);

	property p_irq_edge;
		!irq_on ##1 irq_on;
	endproperty
	c_irq_edge: cover property (p_irq_edge);

	property p_both;
		scsi_pending && dma_pending;
	endproperty
	c_both: cover property (p_both);
endmodule // irq_unit

// [include/irq_defs.svh]
// What this block does
// - every DMA condition is fatal
// - initiator: five SCSI conditions non-fatal, rest fatal
// - target mode adds attention as non-fatal
// - on-the-fly interrupt never halts the engine
// - fatal always halts; non-fatal only if enabled
// - enable bits per condition, cleared means masked
// - masked non-fatal: flag only, no pending, no request
// - masked fatal: halt, flag, pending, no request
// - masking later never drops an asserted request
// - pending set: new conditions OR into hidden level
// - clearing read: request low three clocks, then restack
// - masked non-fatal never causes stacking
// - same-window conditions all posted first level
// - SCSI posting waits for empty DMA FIFO
// - fetch completes, fetched instruction not executed
// - SCSI halt while writing memory flushes FIFO
// - started request/acknowledge handshake finishes first
// - outstanding synchronous offset resolved before halting
// - transfer-control instruction runs to completion
// - phase jump loads transfer address as the drain ends, in the cycle halt or flush begins
// - on-the-fly flag cleared only by writing one
// - FIFO-empty bit is status, never cleared
// - summary always readable; status reads clear
`ifndef IRQ_DEFS_SVH
`define IRQ_DEFS_SVH

// =====================================
// register offsets
`define OFS_SUMMARY   8'h00
`define OFS_SFLAGS0   8'h04
`define OFS_SFLAGS1   8'h08
`define OFS_DFLAGS    8'h0c
`define OFS_SMASK0    8'h10
`define OFS_SMASK1    8'h14
`define OFS_DMASK     8'h18
`define OFS_SCTL1     8'h1c

// =====================================
// field positions
`define SUM_DMA       0
`define SUM_SCSI      1
`define SUM_OTF       2
`define SUM_HALTED    3
`define SUM_RESTART   4
`define CTL_TARGET    0
`define CTL_NO_HALT   1
`define DFE_BIT       7

// =====================================
// non-fatal condition sets, reset values and request gap length
`define NF0_INIT      8'h70
`define NF0_TGT       8'h80
`define NF1_ALL       8'h03
`define MASK_RST      8'h00
`define DMASK_RST     7'h00
`define GAP_CLKS      2'h3

`endif

// [include/irq_pkg.sv]
package irq_pkg;

	typedef struct packed {
		logic fetch_active;
		logic bus_fault;
		logic dma_to_mem;
		logic handshake_active;
		logic offset_outstanding;
		logic xfer_ctl_active;
		logic phase_jump;
	} eng_status_t;

	typedef enum logic [3:0] {
		H_RUN   = 4'b0001,
		H_DRAIN = 4'b0010,
		H_FLUSH = 4'b0100,
		H_HALT  = 4'b1000
	} halt_state_t;

endpackage

// [design/irq_sort.sv]
`include "irq_defs.svh"

module irq_sort (
	// mode
	input  wire logic       target,
	input  wire logic       no_halt_on_attn,
	// enables
	input  wire logic [7:0] en0,
	input  wire logic [7:0] en1,
	// classes
	output logic      [7:0] pc0,
	output logic      [7:0] pc1,
	output logic      [7:0] hc0,
	output logic      [7:0] hc1
);
	wire [7:0] nf0 = `NF0_INIT | (target ? `NF0_TGT : 8'h00);
	wire [7:0] nf1 = `NF1_ALL;
	wire [7:0] keep = (target & no_halt_on_attn) ? `NF0_TGT : 8'h00;

	// pending class: fatal or enabled
	assign pc0 = ~nf0 | en0;
	assign pc1 = ~nf1 | en1;
	// halt class: fatal always, non-fatal when enabled, except attention in target mode with no_halt_on_attn set
	assign hc0 = ~nf0 | (en0 & ~keep);
	assign hc1 = ~nf1 | en1;
endmodule // irq_sort

// [design/halt_ctrl.sv]
module halt_ctrl (
	// clock and reset
	input  wire logic                clk,
	input  wire logic                rst_n,
	// triggers
	input  wire logic                trig,
	input  wire logic                scsi_cause,
	input  wire logic                restart,
	input  wire logic                fifo_empty,
	input  irq_pkg::eng_status_t     eng,
	// engine control
	output logic                     halted,
	output logic                     flush_req,
	output logic                     skip_exec,
	output logic                     load_jump_addr
);
	irq_pkg::halt_state_t state;
	irq_pkg::halt_state_t next_state;
	logic                 cause;
	logic                 ljmp;

	wire ready = (~eng.fetch_active | eng.bus_fault)
		& ~eng.handshake_active
		& ~eng.offset_outstanding
		& ~eng.xfer_ctl_active;
	wire need_flush = cause & eng.dma_to_mem & ~fifo_empty;

	always_comb begin
		next_state = state;
		case (state)
			irq_pkg::H_RUN: if (trig) next_state = irq_pkg::H_DRAIN;
			irq_pkg::H_DRAIN: if (ready) begin
				next_state = need_flush ? irq_pkg::H_FLUSH : irq_pkg::H_HALT;
			end
			irq_pkg::H_FLUSH: if (fifo_empty) next_state = irq_pkg::H_HALT;
			irq_pkg::H_HALT: if (restart) next_state = irq_pkg::H_RUN;
			default: next_state = irq_pkg::H_RUN;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state <= irq_pkg::H_RUN;
			cause <= 1'b0;
			ljmp  <= 1'b0;
		end else begin
			state <= next_state;
			if (state == irq_pkg::H_RUN) cause <= scsi_cause;
			ljmp  <= (state == irq_pkg::H_DRAIN) & ready & eng.phase_jump;
		end
	end

	assign halted         = (state == irq_pkg::H_HALT);
	assign flush_req      = (state == irq_pkg::H_FLUSH);
	assign skip_exec      = (state != irq_pkg::H_RUN);
	assign load_jump_addr = ljmp;
endmodule // halt_ctrl

// [tb/host_irq_model.sv]
module host_irq_model (
	// clock and reset
	input  wire logic clk,
	input  wire logic rst_n,
	// request line
	input  wire logic irq_n,
	// service statistics
	output int        n_req,
	output int        min_gap
);
	timeunit 1ns;
	timeprecision 1ps;

	logic prev;
	int   gap;

	// =====================================
	// count requests and the idle gap before each
	always @(posedge clk) begin
		if (!rst_n) begin
			n_req <= 0;
			min_gap <= 99;
			gap <= 0;
			prev <= 1'b1;
		end else begin
			prev <= irq_n;
			if (irq_n)
				gap <= gap + 1;
			if (prev && !irq_n) begin
				n_req <= n_req + 1;
				if (n_req > 0 && gap < min_gap)
					min_gap <= gap;
				gap <= 0;
			end
		end
	end
endmodule // host_irq_model

// [tb/testbench.sv]
`include "irq_defs.svh"

module testbench;
	timeunit 1ns;
	timeprecision 1ps;

	logic                 clk = 1'b0;
	logic                 rst_n = 1'b0;
	logic                 read = 1'b0;
	logic                 write = 1'b0;
	logic                 otf_evt = 1'b0;
	logic                 dma_fifo_empty = 1'b1;
	logic [7:0]           address = 8'h00;
	logic [7:0]           scsi_evt0 = 8'h00;
	logic [7:0]           scsi_evt1 = 8'h00;
	logic [6:0]           dma_evt = 7'h00;
	logic [31:0]          writedata = 32'h0;
	logic [3:0]           byteenable = 4'h0;
	irq_pkg::eng_status_t eng = '0;
	logic [31:0]          readdata;
	logic                 waitrequest, halted, flush_req, skip_exec, load_jump_addr, irq_n;
	logic [7:0]           q, a, b, e;
	logic                 seen;
	int                   n_fail = 0, cmp_count = 0, n_req, min_gap;
	int                   seed = 32'h8f25e7d1;

	always #12.5 clk = ~clk;

	irq_unit u_dut (.clk, .rst_n, .address, .read, .write, .writedata, .byteenable,
		.readdata, .waitrequest, .scsi_evt0, .scsi_evt1, .dma_evt, .otf_evt,
		.dma_fifo_empty, .eng, .halted, .flush_req, .skip_exec, .load_jump_addr, .irq_n);

	host_irq_model u_host (.clk, .rst_n, .irq_n, .n_req, .min_gap);

	// =====================================
	// helpers
	task end_sim;
		$display("checks %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task bus(input logic wr, input logic [7:0] ad, input logic [7:0] d, input logic [3:0] be);
		@(posedge clk);
		read <= ~wr;
		write <= wr;
		address <= ad;
		writedata <= {24'h0, d};
		byteenable <= be;
		// sampled at the rising edge, before the edge's own updates
		do begin
			@(posedge clk);
		end while (waitrequest !== 1'b0);
		q = readdata[7:0];
		read <= 1'b0;
		write <= 1'b0;
	endtask

	task wr(input logic [7:0] ad, input logic [7:0] d);
		bus(1'b1, ad, d, 4'h1);
	endtask

	task rd(input logic [7:0] ad, input logic [7:0] exp);
		bus(1'b0, ad, 8'h00, 4'h0);
		chk(q, exp);
	endtask

	task pulse(input logic [7:0] s0, input logic [7:0] s1, input logic [6:0] d, input logic o);
		@(posedge clk);
		scsi_evt0 <= s0;
		scsi_evt1 <= s1;
		dma_evt <= d;
		otf_evt <= o;
		@(posedge clk);
		scsi_evt0 <= 8'h00;
		scsi_evt1 <= 8'h00;
		dma_evt <= 7'h00;
		otf_evt <= 1'b0;
		repeat (3) @(posedge clk);
	endtask

	function automatic logic fatal(int m, int i);
		logic [7:0] nf;
		nf = (m != 0) ? 8'hf0 : 8'h70;
		if (i >= 8)
			return i >= 10;
		return ~nf[i];
	endfunction

	// =====================================
	// watchdog
	initial begin
		repeat (20000) @(posedge clk);
		n_fail++;
		end_sim();
	end

	// =====================================
	// tests
	initial begin
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		rd(`OFS_SUMMARY, 8'h00);
		rd(`OFS_SMASK0, `MASK_RST);
		rd(`OFS_DMASK, 8'h00);
		rd(`OFS_DFLAGS, 8'h80);
		rd(8'h40, 8'h00);
		bus(1'b1, `OFS_SMASK0, 8'hff, 4'h0);
		rd(`OFS_SMASK0, 8'h00);
		$display("test reset done");
		for (int m = 0; m < 2; m++) begin
			wr(`OFS_SCTL1, 8'(m));
			for (int i = 0; i < 16; i++) begin
				e = 8'h01 << i[2:0];
				pulse(i < 8 ? e : 8'h00, i < 8 ? 8'h00 : e, 7'h00, 1'b0);
				rd(`OFS_SUMMARY, fatal(m, i) ? 8'h0a : 8'h00);
				chk(irq_n, 1'b1);
				rd(i < 8 ? `OFS_SFLAGS0 : `OFS_SFLAGS1, e);
				wr(`OFS_SUMMARY, 8'h10);
			end
		end
		wr(`OFS_SCTL1, 8'h00);
		pulse(8'h40, 8'h00, 7'h00, 1'b0);
		pulse(8'h01, 8'h00, 7'h00, 1'b0);
		rd(`OFS_SUMMARY, 8'h0a);
		rd(`OFS_SFLAGS0, 8'h41);
		wr(`OFS_SUMMARY, 8'h10);
		$display("test classes done");
		wr(`OFS_SMASK0, 8'hff);
		wr(`OFS_SMASK1, 8'hff);
		wr(`OFS_DMASK, 8'h7f);
		a = (8'($random(seed)) & 8'h7f) | 8'h01;
		b = (8'($random(seed)) & 8'h7f) | 8'h02;
		pulse(8'h00, 8'h00, a[6:0], 1'b0);
		chk(irq_n, 1'b0);
		pulse(8'h00, 8'h00, b[6:0], 1'b0);
		rd(`OFS_SUMMARY, 8'h09);
		rd(`OFS_DFLAGS, a | 8'h80);
		repeat (12) @(posedge clk);
		chk(irq_n, 1'b0);
		wr(`OFS_DMASK, 8'h00);
		repeat (2) @(posedge clk);
		chk(irq_n, 1'b0);
		rd(`OFS_DFLAGS, b | 8'h80);
		chk(min_gap >= 3, 1'b1);
		chk(n_req, 2);
		wr(`OFS_SUMMARY, 8'h10);
		pulse(8'h01, 8'h00, 7'h02, 1'b0);
		rd(`OFS_SUMMARY, 8'h0b);
		rd(`OFS_SFLAGS0, 8'h01);
		repeat (12) @(posedge clk);
		rd(`OFS_DFLAGS, 8'h82);
		wr(`OFS_SUMMARY, 8'h10);
		$display("test stacking done");
		pulse(8'h00, 8'h00, 7'h00, 1'b1);
		rd(`OFS_SUMMARY, 8'h04);
		wr(`OFS_SUMMARY, 8'h00);
		rd(`OFS_SUMMARY, 8'h04);
		wr(`OFS_SUMMARY, 8'h04);
		rd(`OFS_SUMMARY, 8'h00);
		wr(`OFS_SCTL1, 8'h03);
		pulse(8'h80, 8'h00, 7'h00, 1'b0);
		rd(`OFS_SUMMARY, 8'h02);
		chk(irq_n, 1'b0);
		chk(skip_exec, 1'b0);
		rd(`OFS_SFLAGS0, 8'h80);
		wr(`OFS_SCTL1, 8'h00);
		$display("test on_the_fly done");
		@(posedge clk);
		eng <= 7'h5f;
		dma_fifo_empty <= 1'b0;
		pulse(8'h01, 8'h00, 7'h00, 1'b0);
		rd(`OFS_SUMMARY, 8'h00);
		dma_fifo_empty <= 1'b1;
		repeat (3) @(posedge clk);
		@(negedge clk);
		chk(skip_exec, 1'b1);
		chk(halted, 1'b0);
		@(posedge clk);
		dma_fifo_empty <= 1'b0;
		@(posedge clk);
		eng <= 7'h11;
		seen = 1'b0;
		repeat (4) begin
			@(negedge clk);
			seen = seen | load_jump_addr;
		end
		chk(seen, 1'b1);
		chk(flush_req, 1'b1);
		chk(halted, 1'b0);
		@(posedge clk);
		dma_fifo_empty <= 1'b1;
		repeat (3) @(negedge clk);
		chk(halted, 1'b1);
		chk(flush_req, 1'b0);
		@(posedge clk);
		eng <= '0;
		rd(`OFS_SFLAGS0, 8'h01);
		wr(`OFS_SUMMARY, 8'h10);
		$display("test halt done");
		end_sim();
	end
endmodule // testbench
